// *** hw/ebrf_formatter.sv ***
`timescale 1ns/100ps
module ebrf_formatter #(
   parameter logic [15:0] FW_REVISION = 16'h0a05 // arbitrary value
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register read port
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   output logic reg_ack,
   output logic [31:0] reg_rdata,
   // converted event from the front end
   input wire logic conv_valid,
   output logic conv_ready,
   input wire ebrf_pkg::ebrf_sample_t [31:0] conv_samples,
   input wire logic [23:0] event_count,
   // configuration levels
   input wire logic [4:0] slot_position,
   input wire logic [7:0] chassis_number,
   input wire logic [15:0] bit_set_2,
   input wire logic narrow_variant,
   // status
   output logic buffer_empty,
   output logic buffer_full,
   output logic [7:0] event_write_ptr
);

   // ****************************************************************
   // event capture and formatter state
   // ****************************************************************
   ebrf_pkg::ebrf_state_t st;
   ebrf_pkg::ebrf_state_t next_st;
   ebrf_pkg::ebrf_sample_t [31:0] smp;
   logic [23:0] ev_cnt;
   logic [4:0] geo;
   logic [7:0] chas;
   logic [5:0] cnt;
   logic [5:0] next_cnt;
   logic [4:0] idx;
   logic narrow;

   // keep test for one sample
   function automatic logic keep_sample(ebrf_pkg::ebrf_sample_t s, logic keep_below);
      keep_sample = s.enabled && !s.overflow && (!s.below || keep_below);
   endfunction : keep_sample

   // below-threshold storage enable
   wire keep_below = bit_set_2[ebrf_pkg::KEEP_BELOW_BIT_A]
      || bit_set_2[ebrf_pkg::KEEP_BELOW_BIT_B];

   // count of channels that will be stored
   always_comb begin
      next_cnt = 6'h00;
      for (int i = 0; i < 32; i++) begin
         if (keep_sample(conv_samples[i], keep_below) && (!narrow_variant || i < 16)) begin
            next_cnt = next_cnt + 6'h01;
         end
      end
   end

   // interleaved channel walk: 0,half,1,half+1,...
   wire [4:0] cur_ch = narrow ? {1'b0, idx[0], idx[3:1]} : {idx[0], idx[4:1]};
   wire [4:0] last_idx = narrow ? ebrf_pkg::LAST_IDX_NARROW : ebrf_pkg::LAST_IDX_WIDE;
   wire ebrf_pkg::ebrf_sample_t cur = smp[cur_ch];
   wire cur_keep = keep_sample(cur, keep_below);
   wire [4:0] chan_field = narrow ? {cur_ch[3:0], 1'b0} : cur_ch;

   // ****************************************************************
   // record words
   // ****************************************************************
   wire [31:0] hdr_word = {geo, ebrf_pkg::TYPE_HEADER, chas, 2'b00, cnt, 8'h00};
   wire [31:0] dat_word = {geo, ebrf_pkg::TYPE_DATUM, 3'b000, chan_field, 2'b00,
      cur.below, cur.overflow, cur.value};
   wire [31:0] eob_word = {geo, ebrf_pkg::TYPE_TRAILER, ev_cnt};
   wire [31:0] bad_word = {5'h00, ebrf_pkg::TYPE_INVALID, 24'h000000};

   // word presented to the buffer
   wire push_valid = (st == ebrf_pkg::ST_HEAD) || (st == ebrf_pkg::ST_TAIL)
      || (st == ebrf_pkg::ST_DATA && cur_keep);
   wire [31:0] push_word = (st == ebrf_pkg::ST_HEAD) ? hdr_word :
      (st == ebrf_pkg::ST_TAIL) ? eob_word : dat_word;
   logic push_ready;
   wire step = !push_valid || push_ready;
   wire take = conv_valid && conv_ready;
   assign conv_ready = (st == ebrf_pkg::ST_IDLE);

   // ****************************************************************
   // formatter sequence
   // ****************************************************************
   // header, then walk, then trailer; empty events are dropped
   always_comb begin
      next_st = st;
      case (st)
         ebrf_pkg::ST_IDLE: begin
            if (take && next_cnt != 6'h00) next_st = ebrf_pkg::ST_HEAD;
         end
         ebrf_pkg::ST_HEAD: begin
            if (push_ready) next_st = ebrf_pkg::ST_DATA;
         end
         ebrf_pkg::ST_DATA: begin
            if (step && idx == last_idx) next_st = ebrf_pkg::ST_TAIL;
         end
         ebrf_pkg::ST_TAIL: begin
            if (push_ready) next_st = ebrf_pkg::ST_IDLE;
         end
         default: next_st = ebrf_pkg::ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) st <= ebrf_pkg::ST_IDLE;
      else st <= next_st;
   end

   // channel walk index
   always_ff @(posedge clk or posedge rst) begin
      if (rst) idx <= 5'h00;
      else if (st == ebrf_pkg::ST_HEAD) idx <= 5'h00;
      else if (st == ebrf_pkg::ST_DATA && step) idx <= idx + 5'h01;
   end

   // event capture at acceptance
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         smp <= '0;
         ev_cnt <= 24'h000000;
         geo <= 5'h00;
         chas <= 8'h00;
         cnt <= 6'h00;
         narrow <= 1'b0;
      end else if (take) begin
         smp <= conv_samples;
         ev_cnt <= event_count;
         geo <= slot_position;
         chas <= chassis_number;
         cnt <= next_cnt;
         narrow <= narrow_variant;
      end
   end

   // event slot pointer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) event_write_ptr <= ebrf_pkg::EVT_PTR_RESET;
      else if (st == ebrf_pkg::ST_TAIL && push_ready) event_write_ptr <= event_write_ptr + 8'h01;
   end

   // ****************************************************************
   // two-entry buffer and event memory
   // ****************************************************************
   logic drain_valid;
   logic [31:0] drain_word;
   logic [31:0] mem [0:ebrf_pkg::MEM_WORDS-1];
   logic [8:0] wr_ptr;
   logic [8:0] rd_ptr;
   logic [9:0] occ;

   ebrf_skid_buffer #(
      .WIDTH(32)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_word),
      .out_valid(drain_valid),
      .out_ready(!buffer_full),
      .out_data(drain_word)
   );

   // address decode and read selection
   wire win_hit = (reg_addr[15:11] == ebrf_pkg::OFF_WINDOW_LO[15:11])
      && (reg_addr[1:0] == 2'b00);
   wire fw_hit = (reg_addr == ebrf_pkg::OFF_FW_REV);
   wire wr_en = drain_valid && !buffer_full;
   wire rd_en = reg_rd && win_hit && !buffer_empty;
   assign buffer_empty = (occ == 10'h000);
   assign buffer_full = (occ == ebrf_pkg::MEM_FULL);
   wire [31:0] next_rdata = win_hit ? (buffer_empty ? bad_word : mem[rd_ptr]) :
      fw_hit ? {16'h0000, FW_REVISION} : 32'h00000000;

   // storage array
   always_ff @(posedge clk) begin
      if (wr_en) mem[wr_ptr] <= drain_word;
   end

   // pointers and occupancy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= 9'h000;
         rd_ptr <= 9'h000;
         occ <= 10'h000;
      end else begin
         if (wr_en) wr_ptr <= wr_ptr + 9'h001;
         if (rd_en) rd_ptr <= rd_ptr + 9'h001;
         occ <= occ + {9'h000, wr_en} - {9'h000, rd_en};
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_ack <= 1'b0;
         reg_rdata <= ebrf_pkg::RDATA_RESET;
      end else begin
         reg_ack <= reg_rd;
         reg_rdata <= reg_rd ? next_rdata : reg_rdata;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_head_sent;
      st == ebrf_pkg::ST_HEAD && push_ready;
   endsequence
   sequence s_walk_done;
      st == ebrf_pkg::ST_DATA && step && idx == last_idx;
   endsequence
   sequence s_tail_sent;
      st == ebrf_pkg::ST_TAIL && push_ready;
   endsequence

   a_frame_order: assert property (s_head_sent |=> st == ebrf_pkg::ST_DATA && idx == 5'h00)
      else $error("header not followed by data walk");
   a_walk_to_tail: assert property (s_walk_done |=> st == ebrf_pkg::ST_TAIL)
      else $error("walk end not followed by trailer");
   a_header_fields: assert property (st == ebrf_pkg::ST_HEAD |->
      push_word[26:24] == 3'h2 && push_word[23:16] == chas
      && push_word[13:8] == cnt && push_word[15:14] == 2'b00 && push_word[7:0] == 8'h00)
      else $error("header word fields wrong");
   a_slot_field: assert property (push_valid |-> push_word[31:27] == geo)
      else $error("slot position missing");
   a_data_fields: assert property (st == ebrf_pkg::ST_DATA && push_valid |->
      push_word[26:24] == 3'h0 && push_word[13] == cur.below
      && push_word[12] == 1'b0 && push_word[11:0] == cur.value)
      else $error("data word fields wrong");
   a_skip_stored: assert property (st == ebrf_pkg::ST_DATA && push_valid |->
      cur.enabled && !cur.overflow && (!cur.below || keep_below))
      else $error("skipped channel was stored");
   a_chan_order: assert property (st == ebrf_pkg::ST_DATA && !narrow && push_valid |->
      push_word[20:16] == {idx[0], idx[4:1]})
      else $error("channel order wrong");
   a_tail_fields: assert property (st == ebrf_pkg::ST_TAIL |->
      push_word[26:24] == 3'h4 && push_word[23:0] == ev_cnt)
      else $error("trailer word fields wrong");
   a_event_ptr: assert property (s_tail_sent |=> event_write_ptr == $past(event_write_ptr) + 8'h01)
      else $error("event pointer did not advance");
   a_empty_read: assert property (reg_rd && win_hit && buffer_empty |=>
      reg_ack && reg_rdata[26:24] == 3'h6 && reg_rdata[31:27] == 5'h00)
      else $error("empty read not invalid word");
   a_read_next: assert property (rd_en |=> rd_ptr == $past(rd_ptr) + 9'h001)
      else $error("read did not advance");
   a_fw_read: assert property (reg_rd && reg_addr == 16'h1000 |=>
      reg_rdata == {16'h0000, FW_REVISION})
      else $error("firmware revision read wrong");
   a_window_top: assert property (reg_rd && reg_addr == 16'h07fc && !buffer_empty |=>
      reg_ack && rd_ptr == $past(rd_ptr) + 9'h001)
      else $error("top of window not decoded");

   // narrow walk, spare bits, dropped events, pointer and stall holds
   a_chan_narrow: assert property (st == ebrf_pkg::ST_DATA && narrow && push_valid |->
      push_word[20:16] == {idx[0], idx[3:1], 1'b0})
      else $error("narrow channel order wrong");
   a_data_gaps: assert property (st == ebrf_pkg::ST_DATA && push_valid |->
      push_word[23:21] == 3'b000 && push_word[15:14] == 2'b00)
      else $error("data word spare bits set");
   a_drop_empty: assert property (take && next_cnt == 6'h00 |=>
      st == ebrf_pkg::ST_IDLE && event_write_ptr == $past(event_write_ptr))
      else $error("empty event was stored");
   a_ptr_steady: assert property (!(st == ebrf_pkg::ST_TAIL && push_ready) |=>
      event_write_ptr == $past(event_write_ptr))
      else $error("event pointer moved without trailer");
   a_empty_hold: assert property (reg_rd && win_hit && buffer_empty |=>
      rd_ptr == $past(rd_ptr))
      else $error("empty read moved read pointer");
   a_push_hold: assert property (push_valid && !push_ready |=>
      push_valid && $stable(push_word))
      else $error("stalled word changed");

endmodule : ebrf_formatter

// *** pkg/ebrf_pkg.sv ***
// ****************************************************************
// event record formatter constants and types
// ****************************************************************
package ebrf_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [15:0] OFF_WINDOW_LO = 16'h0000;
   localparam logic [15:0] OFF_WINDOW_HI = 16'h07fc;
   localparam logic [15:0] OFF_FW_REV = 16'h1000;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // ****************************************************************
   // record word layout
   // ****************************************************************
   localparam int SLOT_LSB = 27;
   localparam int TYPE_LSB = 24;
   localparam int CHASSIS_LSB = 16;
   localparam int COUNT_LSB = 8;
   localparam int CHAN_LSB = 16;
   localparam int BELOW_BIT = 13;
   localparam int OVER_BIT = 12;
   localparam int VALUE_LSB = 0;
   localparam int EVCNT_LSB = 0;

   // word type codes
   localparam logic [2:0] TYPE_HEADER = 3'h2;
   localparam logic [2:0] TYPE_DATUM = 3'h0;
   localparam logic [2:0] TYPE_TRAILER = 3'h4;
   localparam logic [2:0] TYPE_INVALID = 3'h6;

   // ****************************************************************
   // buffer sizing and control bits
   // ****************************************************************
   localparam int MEM_WORDS = 512;
   localparam logic [9:0] MEM_FULL = 10'h200;
   localparam int KEEP_BELOW_BIT_A = 3;
   localparam int KEEP_BELOW_BIT_B = 4;
   localparam logic [4:0] LAST_IDX_WIDE = 5'h1f;
   localparam logic [4:0] LAST_IDX_NARROW = 5'h0f;
   localparam logic [7:0] EVT_PTR_RESET = 8'h00;

   // one converted channel as delivered by the front end
   typedef struct packed {
      logic enabled;
      logic below;
      logic overflow;
      logic [11:0] value;
   } ebrf_sample_t;

   // formatter states, gray along header-data-trailer
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_HEAD = 2'h1,
      ST_DATA = 2'h3,
      ST_TAIL = 2'h2
   } ebrf_state_t;

endpackage : ebrf_pkg

// *** hw/ebrf_skid_buffer.sv ***
`timescale 1ns/100ps
module ebrf_skid_buffer #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   logic [1:0] count;
   logic [WIDTH-1:0] entry0;
   logic [WIDTH-1:0] entry1;

   // handshake terms
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = entry0;

   // occupancy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 2'h0;
      end else if (push && !pop) begin
         count <= count + 2'h1;
      end else if (pop && !push) begin
         count <= count - 2'h1;
      end
   end

   // entries, head always in entry0
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         entry0 <= '0;
         entry1 <= '0;
      end else begin
         if (pop) begin
            entry0 <= (push && count == 2'h1) ? in_data : entry1;
         end else if (push && count == 2'h0) begin
            entry0 <= in_data;
         end
         if (push && (count == 2'h2 || (count == 2'h1 && !pop))) begin
            entry1 <= in_data;
         end else if (push && pop && count == 2'h2) begin
            entry1 <= in_data;
         end
      end
   end

endmodule : ebrf_skid_buffer

// *** tb/ebrf_bus_master.sv ***
`timescale 1ns/100ps
// ****************************************************************
// bus master reading the event window
// ****************************************************************
module ebrf_bus_master (
   // clock
   input wire logic clk,
   // read port toward the formatter
   output logic reg_rd,
   output logic [15:0] reg_addr,
   input wire logic reg_ack,
   input wire logic [31:0] reg_rdata
);
   // idle bus at time zero
   initial begin
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
   end

   // one read, held until the answering edge
   task automatic rd(input logic [15:0] addr, output logic [31:0] data, output logic ok);
      @(posedge clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = addr;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~addr; // idle address never repeats the last one
      ok = reg_ack;
      data = reg_rdata;
   endtask : rd
endmodule : ebrf_bus_master

// *** tb/tb_event_buffer_readout_formatter.sv ***
`timescale 1ns/100ps
module tb_event_buffer_readout_formatter;
   logic clk;
   logic rst;
   logic reg_rd;
   logic [15:0] reg_addr;
   logic reg_ack;
   logic [31:0] reg_rdata;
   logic conv_valid;
   logic conv_ready;
   ebrf_pkg::ebrf_sample_t [31:0] conv_samples;
   logic [23:0] event_count;
   logic [4:0] slot_position;
   logic [7:0] chassis_number;
   logic [15:0] bit_set_2;
   logic narrow_variant;
   logic buffer_empty;
   logic buffer_full;
   logic [7:0] event_write_ptr;
   int num_errors;
   int compares;
   logic [31:0] rs;
   logic [31:0] exp_q[$];
   logic [7:0] exp_ptr;
   logic [31:0] d;
   logic ok;
   logic [15:0] ta[4] = '{16'h0000, 16'h07fc, 16'h1000, 16'h0800};
   logic [31:0] te[4] = '{32'h0600_0000, 32'h0600_0000, 32'h0000_0a05, 32'h0000_0000};

   // ****************************************************************
   // design and bus master
   // ****************************************************************
   ebrf_formatter u_ebrf_formatter (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_ack(reg_ack), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
      .conv_ready(conv_ready), .conv_samples(conv_samples), .event_count(event_count),
      .slot_position(slot_position), .chassis_number(chassis_number), .bit_set_2(bit_set_2),
      .narrow_variant(narrow_variant), .buffer_empty(buffer_empty), .buffer_full(buffer_full),
      .event_write_ptr(event_write_ptr));
   ebrf_bus_master u_ebrf_bus_master (.clk(clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_ack(reg_ack), .reg_rdata(reg_rdata));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] rnd();
      rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
      return rs;
   endfunction : rnd

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic test_done();
      if (num_errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   // waits until the formatter is idle
   task automatic wait_ready();
      for (int t = 0; t < 4000 && conv_ready !== 1'b1; t++) begin
         @(posedge clk);
         #1;
      end
      chk("idle wait", 32'h1, {31'h0, conv_ready});
   endtask : wait_ready

   // expected record of the event now on the inputs
   task automatic expect_event();
      logic keep;
      int n;
      int ch;
      logic [5:0] cnt;
      logic [31:0] words[$];
      keep = bit_set_2[3] | bit_set_2[4];
      n = narrow_variant ? 16 : 32;
      cnt = 6'h00;
      for (int i = 0; i < n; i++) begin
         ch = (i % 2 == 1) ? i / 2 + n / 2 : i / 2;
         if (conv_samples[ch].enabled && !conv_samples[ch].overflow &&
               (!conv_samples[ch].below || keep)) begin
            words.push_back({slot_position, ebrf_pkg::TYPE_DATUM, 3'h0,
               narrow_variant ? {ch[3:0], 1'b0} : ch[4:0], 2'h0,
               conv_samples[ch].below, 1'b0, conv_samples[ch].value});
            cnt++;
         end
      end
      if (cnt != 6'h00) begin
         exp_q.push_back({slot_position, ebrf_pkg::TYPE_HEADER, chassis_number, 2'h0, cnt,
            8'h00});
         exp_q = {exp_q, words};
         exp_q.push_back({slot_position, ebrf_pkg::TYPE_TRAILER, event_count});
         exp_ptr++;
      end
   endtask : expect_event

   // offers one event: mode 0 random, 1 all storable, 2 all disabled
   task automatic send(input int mode);
      logic [31:0] r;
      @(posedge clk);
      #1;
      wait_ready();
      for (int c = 0; c < 32; c++) begin
         r = rnd();
         conv_samples[c] = r[14:0];
         conv_samples[c].enabled = (mode == 1) || (mode == 0 && r[20:19] != 2'h0);
         conv_samples[c].overflow = (mode == 0) && r[21] && r[22];
         conv_samples[c].below = (mode == 0) && r[23];
      end
      r = rnd();
      slot_position = r[4:0];
      chassis_number = r[12:5];
      narrow_variant = (mode == 0) && r[13];
      bit_set_2 = r[31:16];
      r = rnd();
      event_count = r[23:0];
      conv_valid = 1'b1;
      @(posedge clk);
      #1;
      conv_valid = 1'b0;
      expect_event();
   endtask : send

   // reads every expected word from random window addresses
   task automatic drain();
      logic [31:0] r;
      while (exp_q.size() > 0) begin
         r = rnd();
         u_ebrf_bus_master.rd({5'h00, r[10:2], 2'h0}, d, ok);
         chk("read ack", 32'h1, {31'h0, ok});
         chk("window word", exp_q.pop_front(), d);
      end
   endtask : drain

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      rst = 1'b1;
      conv_valid = 1'b0;
      conv_samples = '0;
      event_count = 24'h000000;
      slot_position = 5'h00;
      chassis_number = 8'h00;
      bit_set_2 = 16'h0000;
      narrow_variant = 1'b0;
      num_errors = 0;
      compares = 0;
      rs = 32'ha7ead65f;
      exp_ptr = 8'h00;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("reset flags", 32'h5, {29'h0, buffer_empty, buffer_full, conv_ready});
      chk("reset ptr", 32'h0, {24'h0, event_write_ptr});
      chk("reset rdata", 32'h0, reg_rdata);
      // empty window, revision and unmapped reads
      for (int i = 0; i < 4; i++) begin
         u_ebrf_bus_master.rd(ta[i], d, ok);
         chk("table read", te[i], d);
      end
      // one empty event, then random events read back one by one
      send(2);
      for (int e = 0; e < 40; e++) begin
         send(e % 7 == 3 ? 1 : 0);
         wait_ready();
         repeat (3) @(posedge clk);
         #1;
         chk("event ptr", {24'h0, exp_ptr}, {24'h0, event_write_ptr});
         drain();
      end
      // fill the memory until the formatter stalls, then drain it
      repeat (16) send(1);
      repeat (60) @(posedge clk);
      #1;
      chk("full stall", 32'h2, {30'h0, buffer_full, conv_ready});
      drain();
      wait_ready();
      repeat (3) @(posedge clk);
      #1;
      chk("final ptr", {24'h0, exp_ptr}, {24'h0, event_write_ptr});
      chk("final empty", 32'h1, {31'h0, buffer_empty});
      u_ebrf_bus_master.rd(16'h0010, d, ok);
      chk("empty read", 32'h0600_0000, d);
      test_done();
   end

   // watchdog
   initial begin
      #200000;
      num_errors++;
      test_done();
   end
endmodule : tb_event_buffer_readout_formatter
